/* File: rtl/spisd_defines.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SPISD_DEFINES_SVH
`define SPISD_DEFINES_SVH

// ============================================================
// register offsets on the plain register port
`define SPISD_OFF_CTRL    8'hC3
`define SPISD_OFF_STATUS  8'hC4
`define SPISD_OFF_DATA    8'hC5
`define SPISD_OFF_EVENT   8'hC6
`define SPISD_OFF_MASK    8'hC7

// ============================================================
// serial_status bit positions
`define SPISD_ST_DONE     7
`define SPISD_ST_OVF      6
`define SPISD_ST_ABORT    5
`define SPISD_ST_FAULT    4

// ============================================================
// event / mask register bit positions
`define SPISD_EV_DONE     0
`define SPISD_EV_OVF      1
`define SPISD_EV_ABORT    2
`define SPISD_EV_FAULT    3
`define SPISD_EV_W        4

// ============================================================
// reset values
`define SPISD_CTRL_RST    8'h00
`define SPISD_MASK_RST    4'h0
`define SPISD_RXBUF_RST   8'h00

// ============================================================
// timing: master half period is HALF_BASE << rate clock cycles
`define SPISD_HALF_BASE   9'h002
`define SPISD_LAST_EDGE   4'hF
`define SPISD_LAST_BIT    3'h7

`endif

/* File: rtl/spisd_pkg.sv */
// types shared by the spi status and data path
package spisd_pkg;

  // ============================================================
  // serial_control layout, msb first
  typedef struct packed {
    logic rate_select_2;
    logic periph_enable_bit;
    logic select_ignore_bit;
    logic master_select_bit;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic rate_select_1;
    logic rate_select_0;
  } spisd_ctrl_t;

  // ============================================================
  // serial engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MASTER,
    ST_SLAVE
  } spisd_state_t;

endpackage : spisd_pkg

/* File: rtl/spisd_core.sv */
// spi status, interrupt and data buffer path with its serial engine
`timescale 1ns/100ps
`include "spisd_defines.svh"

module spisd_core (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       select_n,
  output logic            tx_irq,
  output logic            rx_err_irq,
  output logic            irq
);

  // ============================================================
  // declarations
  spisd_pkg::spisd_ctrl_t  ctrl_r;
  spisd_pkg::spisd_state_t state_r;
  logic [3:0]              sync1_r;
  logic [3:0]              sync2_r;
  logic                    sck_q_r;
  logic                    sel_q_r;
  logic [7:0]              shreg_r;
  logic [7:0]              rx_buf_r;
  logic                    out_bit_r;
  logic                    sck_r;
  logic [8:0]              half_cnt_r;
  logic [3:0]              edge_cnt_r;
  logic [2:0]              bit_cnt_r;
  logic                    done_p_r;
  logic                    done_flag_r;
  logic                    ovf_flag_r;
  logic                    abort_flag_r;
  logic                    fault_flag_r;
  logic                    arm_done_r;
  logic                    arm_fault_r;
  logic [3:0]              event_r;
  logic [3:0]              mask_r;
  logic [7:0]              rd_data_r;
  logic                    sck_oe_r;
  logic                    mosi_oe_r;
  logic                    miso_oe_r;
  logic                    tx_irq_r;
  logic                    rx_err_irq_r;
  logic                    irq_r;
  logic                    sck_now;
  logic                    mosi_now;
  logic                    miso_now;
  logic                    sel_n_now;
  logic                    wr_ctrl;
  logic                    wr_dat;
  logic                    rd_stat;
  logic                    rd_dat;
  logic                    rd_evt;
  logic                    busy;
  logic                    selected;
  logic                    lead_e;
  logic                    trail_e;
  logic                    sample_e;
  logic                    shift_e;
  logic                    ovf_evt;
  logic                    abort_evt;
  logic                    fault_evt;
  logic                    data_touch;
  logic [8:0]              half_lim;
  logic [3:0]              new_evt;

  // address match, used by the strobe decodes below; the read port uses its own case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // master half period from the three rate bits
  function automatic logic [8:0] half_len(input logic [2:0] rate);
    half_len = (`SPISD_HALF_BASE << rate) - 9'h001;
  endfunction : half_len

  // ============================================================
  // pin synchronisers: sck, mosi, miso, select
  // sck presets low like its idle pin, so no false edge after reset
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          sync1_r[g] <= (g == 0) ? 1'b0 : 1'b1;
          sync2_r[g] <= (g == 0) ? 1'b0 : 1'b1;
        end else begin
          sync1_r[g] <= (g == 0) ? sck_in : (g == 1) ? mosi_in :
                        (g == 2) ? miso_in : select_n;
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  assign sck_now   = sync2_r[0];
  assign mosi_now  = sync2_r[1];
  assign miso_now  = sync2_r[2];
  assign sel_n_now = sync2_r[3];

  // previous synced levels for edge finding
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sck_q_r <= 1'b0;
      sel_q_r <= 1'b1;
    end else begin
      sck_q_r <= sck_now;
      sel_q_r <= sel_n_now;
    end
  end

  // ============================================================
  // register decode and serial event terms
  assign wr_ctrl  = wr_en && hit(addr, `SPISD_OFF_CTRL);
  assign wr_dat   = wr_en && hit(addr, `SPISD_OFF_DATA);
  assign rd_stat  = rd_en && hit(addr, `SPISD_OFF_STATUS);
  assign rd_dat   = rd_en && hit(addr, `SPISD_OFF_DATA);
  assign rd_evt   = rd_en && hit(addr, `SPISD_OFF_EVENT);
  assign busy     = (state_r != spisd_pkg::ST_IDLE);
  assign half_lim = half_len({ctrl_r.rate_select_2, ctrl_r.rate_select_1,
                              ctrl_r.rate_select_0});
  assign selected = ctrl_r.select_ignore_bit || !sel_n_now;

  // leading edge leaves the idle polarity, trailing edge returns to it
  assign lead_e   = (sck_q_r == ctrl_r.clock_polarity_bit) &&
                    (sck_now != ctrl_r.clock_polarity_bit);
  assign trail_e  = (sck_q_r != ctrl_r.clock_polarity_bit) &&
                    (sck_now == ctrl_r.clock_polarity_bit);
  assign sample_e = ctrl_r.clock_phase_bit ? trail_e : lead_e;
  assign shift_e  = ctrl_r.clock_phase_bit ? lead_e : trail_e;

  assign ovf_evt   = wr_dat && busy;
  assign abort_evt = ctrl_r.periph_enable_bit && !ctrl_r.master_select_bit &&
                     !ctrl_r.select_ignore_bit &&
                     (state_r == spisd_pkg::ST_SLAVE) && !sel_q_r && sel_n_now;
  assign fault_evt = ctrl_r.periph_enable_bit && ctrl_r.master_select_bit &&
                     !ctrl_r.select_ignore_bit && !sel_n_now;
  assign data_touch = wr_dat || rd_dat;

  // ============================================================
  // serial_control: software writes, a role conflict knocks it down
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_r <= `SPISD_CTRL_RST;
    end else if (fault_evt) begin
      ctrl_r.periph_enable_bit <= 1'b0;
      ctrl_r.master_select_bit <= 1'b0;
    end else if (wr_ctrl) begin
      // accepted even mid-exchange; steady fields are software's duty
      ctrl_r <= wr_data;
      // enable stays off until the conflict flag really clears
      if (fault_flag_r && !arm_fault_r) begin
        ctrl_r.periph_enable_bit <= 1'b0;
      end
    end
  end

  // ============================================================
  // serial engine: shift register, master clock, bit counting
  always_ff @(posedge clock) begin
    done_p_r <= 1'b0;
    if (sys_rst) begin
      state_r    <= spisd_pkg::ST_IDLE;
      shreg_r    <= 8'h00;
      out_bit_r  <= 1'b0;
      sck_r      <= 1'b0;
      half_cnt_r <= 9'h000;
      edge_cnt_r <= 4'h0;
      bit_cnt_r  <= 3'h0;
    end else if (!ctrl_r.periph_enable_bit) begin
      // dropping enable abandons any byte in flight
      state_r    <= spisd_pkg::ST_IDLE;
      sck_r      <= ctrl_r.clock_polarity_bit;
      half_cnt_r <= 9'h000;
      edge_cnt_r <= 4'h0;
      bit_cnt_r  <= 3'h0;
      if (wr_dat) begin
        shreg_r   <= wr_data;
        out_bit_r <= wr_data[7];
      end
    end else if (ctrl_r.master_select_bit) begin
      if (state_r == spisd_pkg::ST_IDLE) begin
        sck_r <= ctrl_r.clock_polarity_bit;
        if (wr_dat) begin
          shreg_r    <= wr_data;
          out_bit_r  <= wr_data[7];
          half_cnt_r <= 9'h000;
          edge_cnt_r <= 4'h0;
          state_r    <= spisd_pkg::ST_MASTER;
        end
      end else if (half_cnt_r == half_lim) begin
        half_cnt_r <= 9'h000;
        sck_r      <= ~sck_r;
        edge_cnt_r <= edge_cnt_r + 4'h1;
        // even edges lead, odd edges trail
        if (edge_cnt_r[0] == ctrl_r.clock_phase_bit) begin
          shreg_r <= {shreg_r[6:0], miso_now};
        end else begin
          out_bit_r <= shreg_r[7];
        end
        if (edge_cnt_r == `SPISD_LAST_EDGE) begin
          state_r  <= spisd_pkg::ST_IDLE;
          done_p_r <= 1'b1;
        end
      end else begin
        half_cnt_r <= half_cnt_r + 9'h001;
      end
    end else begin
      // slave: edges come from the far master's clock
      if (abort_evt) begin
        state_r   <= spisd_pkg::ST_IDLE;
        bit_cnt_r <= 3'h0;
      end else if (selected && sample_e) begin
        shreg_r   <= {shreg_r[6:0], mosi_now};
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == `SPISD_LAST_BIT) begin
          state_r  <= spisd_pkg::ST_IDLE;
          done_p_r <= 1'b1;
        end else begin
          state_r <= spisd_pkg::ST_SLAVE;
        end
      end else if (selected && shift_e) begin
        out_bit_r <= shreg_r[7];
        if (bit_cnt_r != 3'h0 || ctrl_r.clock_phase_bit) begin
          state_r <= spisd_pkg::ST_SLAVE;
        end
      end else if (wr_dat && !busy) begin
        shreg_r   <= wr_data;
        out_bit_r <= wr_data[7];
      end
    end
  end

  // ============================================================
  // receive buffer: only the first byte after the flag cleared lands
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_buf_r <= `SPISD_RXBUF_RST;
    end else if (done_p_r && (!done_flag_r || (arm_done_r && data_touch))) begin
      rx_buf_r <= shreg_r;
    end
  end

  // ============================================================
  // status flags; a new event beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_flag_r  <= 1'b0;
      ovf_flag_r   <= 1'b0;
      abort_flag_r <= 1'b0;
      fault_flag_r <= 1'b0;
      arm_done_r   <= 1'b0;
      arm_fault_r  <= 1'b0;
    end else begin
      // lost overrun bytes set nothing here
      if (done_p_r) begin
        done_flag_r <= 1'b1;
      end else if (arm_done_r && data_touch) begin
        done_flag_r <= 1'b0;
      end
      if (ovf_evt) begin
        ovf_flag_r <= 1'b1;
      end else if (arm_done_r && data_touch) begin
        ovf_flag_r <= 1'b0;
      end
      if (abort_evt) begin
        abort_flag_r <= 1'b1;
      end else if (wr_ctrl && !wr_data[6]) begin
        abort_flag_r <= 1'b0;
      end
      if (fault_evt) begin
        fault_flag_r <= 1'b1;
      end else if (arm_fault_r && wr_ctrl) begin
        fault_flag_r <= 1'b0;
      end
      // a status read with the flag up arms the clearing access
      if (rd_stat && (done_flag_r || ovf_flag_r)) begin
        arm_done_r <= 1'b1;
      end else if (data_touch) begin
        arm_done_r <= 1'b0;
      end
      if (rd_stat && fault_flag_r) begin
        arm_fault_r <= 1'b1;
      end else if (wr_ctrl) begin
        arm_fault_r <= 1'b0;
      end
    end
  end

  // ============================================================
  // sticky events cleared by reading them, with mask
  assign new_evt = {fault_evt, abort_evt, ovf_evt, done_p_r};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      event_r <= 4'h0;
      mask_r  <= `SPISD_MASK_RST;
    end else begin
      event_r <= (rd_evt ? 4'h0 : event_r) | new_evt;
      if (wr_en && hit(addr, `SPISD_OFF_MASK)) begin
        mask_r <= wr_data[3:0];
      end
    end
  end

  // ============================================================
  // interrupt outputs; one cycle behind their flags
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_irq_r     <= 1'b0;
      rx_err_irq_r <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      tx_irq_r     <= done_flag_r;
      // abort flag deliberately feeds neither request line
      rx_err_irq_r <= fault_flag_r && !ctrl_r.select_ignore_bit;
      irq_r        <= |(event_r & mask_r);
    end
  end

  // ============================================================
  // read port: data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst || !rd_en) begin
      rd_data_r <= 8'h00;
    end else begin
      case (addr)
        `SPISD_OFF_CTRL:   rd_data_r <= ctrl_r;
        // reserved low bits read as zero
        `SPISD_OFF_STATUS: rd_data_r <= {done_flag_r, ovf_flag_r,
                                         abort_flag_r, fault_flag_r,
                                         4'h0};
        `SPISD_OFF_DATA:   rd_data_r <= rx_buf_r;
        `SPISD_OFF_EVENT:  rd_data_r <= {4'h0, event_r};
        `SPISD_OFF_MASK:   rd_data_r <= {4'h0, mask_r};
        default:           rd_data_r <= 8'h00;
      endcase
    end
  end

  // ============================================================
  // pin drive enables follow the role
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sck_oe_r  <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      sck_oe_r  <= ctrl_r.periph_enable_bit && ctrl_r.master_select_bit;
      mosi_oe_r <= ctrl_r.periph_enable_bit && ctrl_r.master_select_bit;
      miso_oe_r <= ctrl_r.periph_enable_bit && !ctrl_r.master_select_bit &&
                   selected;
    end
  end

  assign rd_data    = rd_data_r;
  assign sck_out    = sck_r;
  assign sck_oe     = sck_oe_r;
  assign mosi_out   = out_bit_r;
  assign mosi_oe    = mosi_oe_r;
  assign miso_out   = out_bit_r;
  assign miso_oe    = miso_oe_r;
  assign tx_irq     = tx_irq_r;
  assign rx_err_irq = rx_err_irq_r;
  assign irq        = irq_r;

endmodule : spisd_core

/* File: test/spisd_core_sva.sv */
// assertion checker for the spi status and data path
`timescale 1ns/100ps
`include "spisd_defines.svh"
module spisd_core_sva (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       tx_irq,
  input wire logic       rx_err_irq,
  input wire logic       irq
);
  localparam logic [7:0] OC = `SPISD_OFF_CTRL;
  localparam logic [7:0] OS = `SPISD_OFF_STATUS;
  localparam logic [7:0] OM = `SPISD_OFF_MASK;
  logic st_r;
  logic ct_r;
  logic acc_r;
  logic acc2_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ==========
  // remember which read the current rd_data answers
  always_ff @(posedge clock) begin
    st_r   <= rd_en && addr == OS;
    ct_r   <= rd_en && addr == OC;
    acc_r  <= rd_en || wr_en;
    acc2_r <= acc_r;
  end

  // ==========
  // a status read and tx_irq see the same done flag copy; rx_err_irq stays low while select is ignored
  a_status_rsvd: assert property (st_r |-> rd_data[1:0] == 2'h0)
    else $error("reserved status bits not zero");
  a_done_irq: assert property (st_r |-> rd_data[7] == tx_irq)
    else $error("tx irq disagrees with done flag");
  a_ignore_irq: assert property (ct_r && rd_data[5] |-> !rx_err_irq)
    else $error("fault irq while select ignored");
  a_abort_clear: assert property (wr_en && addr == OC && !wr_data[6] ##2
    rd_en && addr == OS |=> !rd_data[5])
    else $error("abort flag survived disable");
  a_fault_drop: assert property ($rose(rx_err_irq) |-> ##[0:2] !sck_oe)
    else $error("master drive kept after fault");
  a_disable_now: assert property (wr_en && addr == OC && !wr_data[6]
    |-> ##[1:2] !(sck_oe || mosi_oe || miso_oe))
    else $error("pins still driven after disable");
  a_done_hold: assert property ($fell(tx_irq) |-> acc2_r)
    else $error("tx irq fell with no access");
  a_mask_irq: assert property (wr_en && addr == OM
    && wr_data[3:0] == 4'h0 |-> ##[1:2] !irq)
    else $error("irq high with all masked");

  c_done: cover property ($rose(tx_irq));
  c_fault: cover property ($rose(rx_err_irq));
  c_abort: cover property (st_r && rd_data[5]);
endmodule : spisd_core_sva

bind spisd_core spisd_core_sva u_spisd_core_sva (.clock(clock),
  .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .tx_irq(tx_irq), .rx_err_irq(rx_err_irq), .irq(irq));

/* File: test/spisd_peer.sv */
// far-side spi device: clocks bytes in as master, answers as slave
`timescale 1ns/100ps
module spisd_peer (
  input  wire logic clock,
  input  wire logic sck_w,
  input  wire logic mosi_w,
  input  wire logic miso_w,
  output logic      m_sck,
  output logic      m_mosi,
  output logic      s_miso,
  output logic      sel_n
);
  logic       m_on;
  logic       s_on;
  logic       prev;
  logic [7:0] s_sh;
  logic [7:0] s_rx;
  logic [7:0] m_rx;
  int         falls;

  // ==========
  // idle pins; sck stands low outside frames
  initial begin
    m_sck = 1'b0;
    m_mosi = 1'b0;
    s_miso = 1'b0;
    sel_n = 1'b1;
    m_on = 1'b0;
    s_on = 1'b0;
    prev = 1'b0;
  end

  // slave role: shift on falling sck, capture on rising sck;
  // released lines flip each cycle so no stale bit passes as data
  always @(posedge clock) begin
    prev <= sck_w;
    if (!m_on) begin
      m_mosi <= ~m_mosi;
    end
    if (!s_on) begin
      s_miso <= ~s_miso;
    end else if (sck_w && !prev) begin
      s_rx <= {s_rx[6:0], mosi_w};
    end else if (!sck_w && prev) begin
      s_sh = s_sh << 1;
      s_miso <= s_sh[7];
      falls++;
      s_on = (falls < 8);
    end
  end

  // preload the answer byte, msb out before the first edge
  task automatic arm_slave(input logic [7:0] tx);
    s_sh = tx;
    falls = 0;
    s_miso <= tx[7];
    s_on = 1'b1;
  endtask : arm_slave

  // master role at 160 ns per bit; fewer than 8 bits aborts the byte
  task automatic send(input logic [7:0] tx, input int nbits);
    logic [7:0] sh;
    sh = tx;
    m_on = 1'b1;
    sel_n <= 1'b0;
    m_mosi <= sh[7];
    for (int i = 0; i < nbits; i++) begin
      repeat (4) @(posedge clock);
      m_rx = {m_rx[6:0], miso_w};
      m_sck <= 1'b1;
      repeat (4) @(posedge clock);
      m_sck <= 1'b0;
      sh = sh << 1;
      m_mosi <= sh[7];
    end
    repeat (4) @(posedge clock);
    sel_n <= 1'b1;
    m_on = 1'b0;
    repeat (4) @(posedge clock);
  endtask : send
endmodule : spisd_peer

/* File: test/spisd_core_tb_top.sv */
// self-checking bench for the spi status and data path
`timescale 1ns/100ps
`include "spisd_defines.svh"
module spisd_core_tb_top;
  localparam logic [7:0] OC = `SPISD_OFF_CTRL;
  localparam logic [7:0] OS = `SPISD_OFF_STATUS;
  localparam logic [7:0] OD = `SPISD_OFF_DATA;
  localparam logic [7:0] OE = `SPISD_OFF_EVENT;
  localparam logic [7:0] OM = `SPISD_OFF_MASK;
  logic       clock, sys_rst, wr_en, rd_en;
  logic [7:0] addr, wr_data, rd_data;
  logic       sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic       tx_irq, rx_err_irq, irq, m_sck, m_mosi, s_miso, sel_n;
  int         bad_count;
  int         checks;
  // pin levels from whoever enables a driver
  wire        sck_w  = sck_oe ? sck_out : m_sck;
  wire        mosi_w = mosi_oe ? mosi_out : m_mosi;
  wire        miso_w = miso_oe ? miso_out : s_miso;

  spisd_core u_spisd_core (
    .clock(clock), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
    .miso_out(miso_out), .miso_oe(miso_oe), .select_n(sel_n),
    .tx_irq(tx_irq), .rx_err_irq(rx_err_irq), .irq(irq));
  spisd_peer u_spisd_peer (
    .clock(clock), .sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w),
    .m_sck(m_sck),
    .m_mosi(m_mosi), .s_miso(s_miso), .sel_n(sel_n));

  // ==========
  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle strobes; an idle cycle after each keeps drives single
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
    @(posedge clock);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rdc

  // bounded wait on the done interrupt; mask holds the done bit
  task automatic wait_done;
    int n;
    n = 0;
    while (tx_irq !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk({6'h00, tx_irq, irq}, 8'h03);
    @(posedge clock);
  endtask : wait_done

  // poll the done event when tx_irq is already stuck high
  task automatic wait_ev;
    logic [7:0] d;
    int n;
    d = 8'h00;
    n = 0;
    while (d[0] !== 1'b1 && n < 200) begin
      rd(OE, d);
      n++;
    end
    chk({7'h00, d[0]}, 8'h01);
  endtask : wait_ev

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // hang guard, far beyond the several hundred cycles the run needs
  initial begin
    repeat (10000) @(posedge clock);
    bad_count++;
    final_report();
  end

  // ==========
  // main sequence; master runs at half period 8 cycles
  initial begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rdc(OC, 8'h00);
    rdc(OS, 8'h00);
    rdc(OD, 8'h00);
    rdc(8'hC0, 8'h00);
    wr(OM, 8'h0D);
    rdc(OM, 8'h0D);
    wr(OM, 8'h01);
    // master byte with a colliding write mid-byte
    wr(OC, 8'h52);
    u_spisd_peer.arm_slave(8'hA5);
    wr(OD, 8'h3C);
    repeat (20) @(posedge clock);
    rdc(OD, 8'h00);
    wr(OD, 8'hFF);
    wait_done();
    chk(u_spisd_peer.s_rx, 8'h3C);
    rdc(OE, 8'h03);
    rdc(OS, 8'hC0);
    rdc(OD, 8'hA5);
    #1;
    chk({7'h00, tx_irq}, 8'h00);
    @(posedge clock);
    // two bytes while done stays set: first one kept, silently
    u_spisd_peer.arm_slave(8'h11);
    wr(OD, 8'h01);
    wait_done();
    rdc(OE, 8'h01);
    u_spisd_peer.arm_slave(8'h22);
    wr(OD, 8'h02);
    wait_ev();
    rdc(OS, 8'h80);
    rdc(OD, 8'h11);
    // enable dropped mid-byte; rate and role bits left alone
    u_spisd_peer.arm_slave(8'h33);
    wr(OD, 8'h44);
    repeat (40) @(posedge clock);
    wr(OC, 8'h12);
    repeat (160) @(posedge clock);
    rdc(OS, 8'h00);
    // select pulled low under an enabled master
    wr(OC, 8'h52);
    u_spisd_peer.sel_n <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk({7'h00, rx_err_irq}, 8'h01);
    @(posedge clock);
    u_spisd_peer.sel_n <= 1'b1;
    rdc(OC, 8'h02);
    wr(OC, 8'h20);
    #1;
    chk({7'h00, rx_err_irq}, 8'h00);
    @(posedge clock);
    wr(OC, 8'h60);
    rdc(OC, 8'h20);
    rdc(OS, 8'h10);
    wr(OC, 8'h00);
    rdc(OS, 8'h00);
    rdc(OE, 8'h08);
    // slave byte, then a byte cut short by select
    wr(OC, 8'h40);
    wr(OD, 8'h5A);
    u_spisd_peer.send(8'h96, 8);
    chk(u_spisd_peer.m_rx, 8'h5A);
    wait_done();
    rdc(OS, 8'h80);
    rdc(OD, 8'h96);
    rdc(OE, 8'h01);
    u_spisd_peer.send(8'h0F, 4);
    rdc(OS, 8'h20);
    rdc(OE, 8'h04);
    #1;
    chk({5'h00, tx_irq, rx_err_irq, irq}, 8'h00);
    @(posedge clock);
    wr(OC, 8'h00);
    rdc(OS, 8'h00);
    wr(OM, 8'h00);
    final_report();
  end
endmodule : spisd_core_tb_top
